// ===== hdl/sdm_direct_ctrl.sv
// Top of the SDRAM direct-mode block: register port, four-phase
// direct-mode handshake, SDRAM control pin mux, memory map outputs.
// Assumes a synchronous register master and that the normal access
// state machines drive the norm_* inputs outside direct mode.
//
// The plain strobed port and the register addresses are this design's own decisions.
module sdm_direct_ctrl
   import sdm_pkg::*;
#(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [AW-1:0] reg_addr_i,
   input  wire logic [DW-1:0] reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic      [DW-1:0] reg_rdata_o,
   input  wire logic          strap_size64_i,
   input  wire logic          strap_second_rom_select_enable_i,
   input  wire logic [2:0]    strap_rsize_i,
   input  wire logic          norm_cke_i,
   input  wire logic          norm_cs_n_i,
   input  wire logic          norm_ras_n_i,
   input  wire logic          norm_cas_n_i,
   input  wire logic          norm_we_n_i,
   input  wire logic [11:0]   norm_addr_i,
   input  wire logic [23:0]   acc_addr_i,
   input  wire logic          acc_valid_i,
   output logic               sdram_cke_o,
   output logic               sdram_cs_n_o,
   output logic               sdram_ras_n_o,
   output logic               sdram_cas_n_o,
   output logic               sdram_we_n_o,
   output logic      [11:0]   sdram_addr_o,
   output logic      [1:0]    sdram_ba_o,
   output logic               sdram_hit_o,
   output logic      [1:0]    sdram_region_o,
   output logic               rom2_cs_n_o,
   output logic               direct_ack_o
);
   typedef struct packed {
      sdm_state_e  st;
      logic        req;
      logic        ack;
      logic [5:0]  dcmd;
      logic        cke_hold;
      logic        cfg_done;
      logic        size64;
      logic        second_rom_select_enable;
      logic [2:0]  rsize;
      logic [DW-1:0] rdata;
      logic        cke;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [11:0] addr;
      logic [1:0]  ba;
      logic        hit;
      logic [1:0]  region;
      logic        rom2_cs_n;
   } sdm_state_s;

   sdm_state_s s_r;
   sdm_state_s s_nxt;
   sdm_dec_if  dif ();
   logic       is_mrs;
   logic       direct;

   // ==========================================================
   // Address decoder
   assign dif.addr   = acc_addr_i;
   assign dif.size64 = s_r.size64;
   assign dif.second_rom_select_enable  = s_r.second_rom_select_enable;
   assign dif.rsize  = s_r.rsize;

   sdm_addr_decode u_dec (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .dec   (dif)
   );

   // Mode-set is all strobes low with select low
   assign is_mrs = s_r.dcmd[4:1] == 4'h0;
   // Direct mode covers the request and the whole handshake
   assign direct = s_r.req || s_r.st != SDM_IDLE;

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      // Straps are caught once, on the first edge after reset
      if (!s_r.cfg_done) begin
         s_nxt.cfg_done = 1'b1;
         s_nxt.size64   = strap_size64_i;
         s_nxt.second_rom_select_enable    = strap_second_rom_select_enable_i;
         s_nxt.rsize    = strap_rsize_i;
      end

      // Register writes; acknowledge has no write path
      if (reg_wr_i) begin
         if (reg_addr_i == SDM_REG_CTRL) begin
            s_nxt.req = reg_wdata_i[SDM_CTRL_REQ];
         end
         if (reg_addr_i == SDM_REG_DCMD) begin
            s_nxt.dcmd = reg_wdata_i[5:0];
         end
      end

      // Read data stands the cycle after the strobe only
      s_nxt.rdata = '0;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            SDM_REG_CTRL: begin
               s_nxt.rdata[SDM_CTRL_REQ]  = s_r.req;
               s_nxt.rdata[SDM_CTRL_ACK]  = s_r.ack;
               s_nxt.rdata[SDM_CTRL_SIZE] = s_r.size64;
               s_nxt.rdata[SDM_CTRL_BUSY] = s_r.st != SDM_IDLE;
            end
            SDM_REG_DCMD: s_nxt.rdata[5:0] = s_r.dcmd;
            SDM_REG_CFG: begin
               s_nxt.rdata[SDM_CFG_SIZE]  = s_r.size64;
               s_nxt.rdata[SDM_CFG_SECOND_ROM_SELECT_ENABLE] = s_r.second_rom_select_enable;
               s_nxt.rdata[SDM_CFG_RSZ+:3] = s_r.rsize;
            end
            default: s_nxt.rdata = '0;
         endcase
      end

      // Four-phase handshake
      unique case (s_r.st)
         SDM_IDLE: begin
            // A new command only on a fresh request
            if (s_r.req && !s_r.ack) begin
               s_nxt.st = SDM_EXEC;
            end
         end
         SDM_EXEC: begin
            // Command was on the pins this cycle, now acknowledge
            s_nxt.st  = SDM_ACK;
            s_nxt.ack = 1'b1;
         end
         SDM_ACK: begin
            // Acknowledge stays while request stays, then drops
            if (!s_r.req) begin
               s_nxt.st  = SDM_IDLE;
               s_nxt.ack = 1'b0;
            end
         end
      endcase

      // Pin mux; all pins are registered for clean timing
      if (s_nxt.st == SDM_EXEC) begin
         // Present the stored pattern for exactly one cycle
         s_nxt.cke      = s_r.dcmd[SDM_DC_CKE];
         s_nxt.cs_n     = s_r.dcmd[SDM_DC_CS];
         s_nxt.ras_n    = s_r.dcmd[SDM_DC_RAS];
         s_nxt.cas_n    = s_r.dcmd[SDM_DC_CAS];
         s_nxt.we_n     = s_r.dcmd[SDM_DC_WE];
         s_nxt.cke_hold = s_r.dcmd[SDM_DC_CKE];
         s_nxt.addr     = '0;
         s_nxt.addr[10] = s_r.dcmd[SDM_DC_A10];
         if (is_mrs && !s_r.dcmd[SDM_DC_CS]) begin
            s_nxt.addr[9:0] = SDM_MODE_WORD;
         end
         s_nxt.ba = '0;
      end else if (direct || s_r.req) begin
         // Bypass: deselect, keep the last commanded clock enable
         s_nxt.cke   = s_r.cke_hold;
         s_nxt.cs_n  = 1'b1;
         s_nxt.ras_n = 1'b1;
         s_nxt.cas_n = 1'b1;
         s_nxt.we_n  = 1'b1;
         s_nxt.addr  = '0;
         s_nxt.ba    = '0;
      end else begin
         // Normal access hardware owns the pins
         s_nxt.cke   = norm_cke_i;
         s_nxt.cs_n  = norm_cs_n_i;
         s_nxt.ras_n = norm_ras_n_i;
         s_nxt.cas_n = norm_cas_n_i;
         s_nxt.we_n  = norm_we_n_i;
         s_nxt.addr  = norm_addr_i;
         s_nxt.ba    = dif.ba;
      end

      // Memory map outputs
      s_nxt.hit       = dif.sdram_hit;
      s_nxt.region    = dif.region;
      s_nxt.rom2_cs_n = !(acc_valid_i && dif.rom2_hit);
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r           <= '0;
         s_r.st        <= SDM_IDLE;
         s_r.dcmd      <= SDM_DCMD_RST;
         s_r.cke_hold  <= SDM_CKE_RST;
         s_r.cke       <= SDM_CKE_RST;
         s_r.cs_n      <= 1'b1;
         s_r.ras_n     <= 1'b1;
         s_r.cas_n     <= 1'b1;
         s_r.we_n      <= 1'b1;
         s_r.second_rom_select_enable     <= 1'b1;
         s_r.rom2_cs_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_o    = s_r.rdata;
   assign sdram_cke_o    = s_r.cke;
   assign sdram_cs_n_o   = s_r.cs_n;
   assign sdram_ras_n_o  = s_r.ras_n;
   assign sdram_cas_n_o  = s_r.cas_n;
   assign sdram_we_n_o   = s_r.we_n;
   assign sdram_addr_o   = s_r.addr;
   assign sdram_ba_o     = s_r.ba;
   assign sdram_hit_o    = s_r.hit;
   assign sdram_region_o = s_r.region;
   assign rom2_cs_n_o    = s_r.rom2_cs_n;
   assign direct_ack_o   = s_r.ack;

   // ==========================================================
   // Checks
   property p_ack_after_exec;
      @(posedge clk_i) disable iff (rst_i)
      $rose(s_r.ack) |-> $past(s_r.st) == SDM_EXEC;
   endproperty
   a_ack_after_exec: assert property (p_ack_after_exec)
      else $error("ack rose without command");

   property p_ack_hold;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.ack && s_r.req) |=> s_r.ack;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("ack dropped under request");

   property p_ack_drop;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.ack && !s_r.req) |=> !s_r.ack;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack not cleared in one cycle");

   property p_idle_quiet;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_IDLE && (!s_r.req || s_r.ack)) |=> s_r.st != SDM_EXEC;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("command without new request");

   property p_pattern;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_EXEC) |-> sdram_cs_n_o == $past(s_r.dcmd[SDM_DC_CS])
         && sdram_ras_n_o == $past(s_r.dcmd[SDM_DC_RAS])
         && sdram_cke_o == $past(s_r.dcmd[SDM_DC_CKE])
         && sdram_addr_o[10] == $past(s_r.dcmd[SDM_DC_A10]);
   endproperty
   a_pattern: assert property (p_pattern)
      else $error("pins differ from command pattern");

   property p_mode_word;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_EXEC && !sdram_cs_n_o && !sdram_ras_n_o
         && !sdram_cas_n_o && !sdram_we_n_o)
         |-> sdram_addr_o[9:0] == SDM_MODE_WORD;
   endproperty
   a_mode_word: assert property (p_mode_word)
      else $error("mode word wrong");

   property p_once;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_EXEC) |=> (s_r.st == SDM_ACK) [*1] ##0 sdram_cs_n_o;
   endproperty
   a_once: assert property (p_once)
      else $error("command driven twice");

   property p_bypass;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_ACK) |-> sdram_cs_n_o && sdram_we_n_o;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("pins not bypassed in direct mode");

   property p_normal;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_IDLE && !s_r.req)
         |=> sdram_cs_n_o == $past(norm_cs_n_i);
   endproperty
   a_normal: assert property (p_normal)
      else $error("normal pins not passed");

   property p_rom2_off;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.cfg_done && (s_r.second_rom_select_enable || s_r.rsize == SDM_RSZ_NONE))
         |=> rom2_cs_n_o;
   endproperty
   a_rom2_off: assert property (p_rom2_off)
      else $error("second ROM selected while disabled");

   // Only the request bit of the control word has a write path
   property p_req_write;
      @(posedge clk_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == SDM_REG_CTRL)
         |=> s_r.req == $past(reg_wdata_i[SDM_CTRL_REQ]);
   endproperty
   a_req_write: assert property (p_req_write)
      else $error("request flag not written");

   property p_idle_no_ack;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_IDLE) |-> !s_r.ack;
   endproperty
   a_idle_no_ack: assert property (p_idle_no_ack)
      else $error("ack set while idle");

   // Address and bank lines stay parked while acknowledge is held
   property p_bypass_addr;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == SDM_ACK) |-> sdram_addr_o == 12'h000 && sdram_ba_o == 2'h0;
   endproperty
   a_bypass_addr: assert property (p_bypass_addr)
      else $error("address not parked in direct mode");
endmodule

// ===== hdl/sdm_pkg.sv
// Shared constants and types for the SDRAM direct-mode block.
// Assumes a single 50 MHz clock domain and a 16-bit register port.
package sdm_pkg;
   // ==========================================================
   // Register map (word index on the register port)
   localparam logic [7:0] SDM_REG_CTRL = 8'h00;
   localparam logic [7:0] SDM_REG_DCMD = 8'h01;
   localparam logic [7:0] SDM_REG_CFG  = 8'h02;

   // ==========================================================
   // Control register fields
   localparam int SDM_CTRL_REQ  = 0;
   localparam int SDM_CTRL_ACK  = 1;
   localparam int SDM_CTRL_SIZE = 2;
   localparam int SDM_CTRL_BUSY = 3;

   // ==========================================================
   // Direct-command register fields
   localparam int SDM_DC_A10 = 0;
   localparam int SDM_DC_WE  = 1;
   localparam int SDM_DC_CAS = 2;
   localparam int SDM_DC_RAS = 3;
   localparam int SDM_DC_CS  = 4;
   localparam int SDM_DC_CKE = 5;
   localparam logic [5:0] SDM_DCMD_RST = 6'h00;
   localparam logic       SDM_CKE_RST  = 1'h1;

   // ==========================================================
   // Configuration register fields (reset-time settings)
   localparam int SDM_CFG_SIZE  = 0;
   localparam int SDM_CFG_SECOND_ROM_SELECT_ENABLE = 1;
   localparam int SDM_CFG_RSZ   = 2;

   // ==========================================================
   // Mode word: CAS latency 3, linear wrap, burst length 4
   localparam logic [9:0] SDM_MODE_WORD = 10'h032;

   // ==========================================================
   // SDRAM address map
   localparam logic [23:0] SDM_SDR16_END = 24'h9F_FFFF;

   // ==========================================================
   // Second ROM base by ROM size code
   localparam logic [2:0]  SDM_RSZ_NONE = 3'h7;
   localparam logic [2:0]  SDM_RSZ_6    = 3'h6;
   localparam logic [2:0]  SDM_RSZ_5    = 3'h5;
   localparam logic [2:0]  SDM_RSZ_4    = 3'h4;
   localparam logic [2:0]  SDM_RSZ_3    = 3'h3;
   localparam logic [23:0] SDM_ROM2_B6  = 24'h20_0000;
   localparam logic [23:0] SDM_ROM2_B5  = 24'h10_0000;
   localparam logic [23:0] SDM_ROM2_B4  = 24'h08_0000;
   localparam logic [23:0] SDM_ROM2_B3  = 24'h04_0000;
   localparam logic [23:0] SDM_ROM2_BX  = 24'h02_0000;

   typedef enum logic [1:0] {SDM_IDLE, SDM_EXEC, SDM_ACK} sdm_state_e;
endpackage

// ===== hdl/sdm_dec_if.sv
// Interface between the control block and its address decoder.
// Assumes both ends share clk_i.
interface sdm_dec_if;
   logic [23:0] addr;
   logic        size64;
   logic        second_rom_select_enable;
   logic [2:0]  rsize;
   logic        sdram_hit;
   logic [1:0]  region;
   logic [1:0]  ba;
   logic        rom2_hit;
   modport dec (input addr, size64, second_rom_select_enable, rsize,
                output sdram_hit, region, ba, rom2_hit);
   modport ctl (output addr, size64, second_rom_select_enable, rsize,
                input sdram_hit, region, ba, rom2_hit);
endinterface

// ===== hdl/sdm_addr_decode.sv
// Address decoder: SDRAM bank ranges and second ROM window.
// Assumes configuration inputs stay stable after reset.
module sdm_addr_decode
   import sdm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   sdm_dec_if.dec   dec
);
   logic [23:0] base;

   // ==========================================================
   // Second ROM base follows the ROM size code
   always_comb begin
      unique case (dec.rsize)
         SDM_RSZ_6: base = SDM_ROM2_B6;
         SDM_RSZ_5: base = SDM_ROM2_B5;
         SDM_RSZ_4: base = SDM_ROM2_B4;
         SDM_RSZ_3: base = SDM_ROM2_B3;
         default:   base = SDM_ROM2_BX;
      endcase
   end

   // ==========================================================
   // Bank ranges and bank select bits per device size
   always_comb begin
      dec.sdram_hit = dec.addr[23] &&
         (dec.size64 || dec.addr <= SDM_SDR16_END);
      dec.region = dec.size64 ? dec.addr[22:21] : {1'b0, dec.addr[20]};
      dec.ba = dec.size64 ? dec.addr[13:12] : {1'b0, dec.addr[11]};
      // Window spans one device of the coded size, from the base up to twice the base
      dec.rom2_hit = !dec.second_rom_select_enable && dec.rsize != SDM_RSZ_NONE
         && dec.addr >= base && dec.addr < {base[22:0], 1'b0};
   end

   property p_bank16;
      @(posedge clk_i) disable iff (rst_i)
      (!dec.size64 && dec.sdram_hit) |-> dec.addr[23:21] == 3'h4
         && dec.region == {1'b0, dec.addr[20]};
   endproperty
   a_bank16: assert property (p_bank16) else $error("16M bank range wrong");

   property p_ba_sel;
      @(posedge clk_i) disable iff (rst_i)
      dec.size64 |-> dec.ba == dec.addr[13:12];
   endproperty
   a_ba_sel: assert property (p_ba_sel) else $error("bank bits wrong");
endmodule

// ===== sim/sdm_sdram_model.sv
// Watch-only model of the SDRAM side: counts control-pin events.
// Assumes the block drives registered pins that settle before each rising edge.
module sdm_sdram_model (
   input  wire logic        clk_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic [11:0] addr_i,
   output logic      [15:0] evt_cnt_o,
   output logic      [3:0]  last_cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cke_q;

   // Power-up: clock enable assumed high, nothing seen yet
   initial begin
      evt_cnt_o  = 16'h0000;
      last_cmd_o = 4'hF;
      cke_q      = 1'h1;
   end

   // ==========================================================
   // Command decode
   // A selected cycle is one command; a clock-enable edge is one more,
   // which is the only trace that power-down and self-refresh exits leave
   always @(posedge clk_i) begin
      evt_cnt_o <= evt_cnt_o + 16'(cs_n_i === 1'b0) + 16'(cke_i !== cke_q);
      cke_q     <= cke_i;
      if (cs_n_i === 1'b0) begin
         last_cmd_o <= {ras_n_i, cas_n_i, we_n_i, addr_i[10]};
      end
   end
endmodule

// ===== sim/sdram_direct_mode_and_memory_map_tb_top.sv
// Self-checking bench for the direct-mode handshake and memory map.
// Assumes straps are held steady across each reset and sampled after release.
module sdram_direct_mode_and_memory_map_tb_top
   import sdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, wr, rd, s64, cse, aval;
   logic [7:0]  radr;
   logic [15:0] wdat, rdat, evt;
   logic [2:0]  rsz;
   logic        nm_cke, nm_cs_n, nm_ras_n, nm_cas_n, nm_we_n;
   logic [11:0] nm_adr, sadr;
   logic [23:0] aadr;
   logic        cke, cs_n, ras_n, cas_n, we_n, hit, rom_n, ack;
   logic [1:0]  ba, region;
   logic [3:0]  lcmd;
   int          mismatches = 0;
   int          num_checks = 0;
   int          seed = 21;
   int          cycles = 0;
   // NOP, PRECHARGE_EVERY_BANK_CMD, AUTO_REFRESH_CMD, self-refresh in/out, power-down in/out, MODE_PROGRAM_CMD twice, DESELECT_CMD
   localparam logic [5:0] CMDS [10] = '{6'h2E, 6'h25, 6'h22, 6'h02, 6'h3E,
                                         6'h1E, 6'h3F, 6'h20, 6'h21, 6'h31};
   localparam logic [23:0] PTS [9] = '{24'h80_0000, 24'h8F_FFFF, 24'h90_0000,
      24'h9F_FFFF, 24'hA0_0000, 24'hC0_0000, 24'hE0_0000, 24'hFF_FFFF, 24'h7F_FFFF};

   sdm_direct_ctrl sdm_direct_ctrl_i (.clk_i(clk), .rst_i(rst), .reg_addr_i(radr),
      .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .strap_size64_i(s64), .strap_second_rom_select_enable_i(cse), .strap_rsize_i(rsz),
      .norm_cke_i(nm_cke), .norm_cs_n_i(nm_cs_n), .norm_ras_n_i(nm_ras_n),
      .norm_cas_n_i(nm_cas_n), .norm_we_n_i(nm_we_n), .norm_addr_i(nm_adr),
      .acc_addr_i(aadr), .acc_valid_i(aval), .sdram_cke_o(cke), .sdram_cs_n_o(cs_n),
      .sdram_ras_n_o(ras_n), .sdram_cas_n_o(cas_n), .sdram_we_n_o(we_n),
      .sdram_addr_o(sadr), .sdram_ba_o(ba), .sdram_hit_o(hit),
      .sdram_region_o(region), .rom2_cs_n_o(rom_n), .direct_ack_o(ack));

   sdm_sdram_model sdm_sdram_model_i (.clk_i(clk), .cke_i(cke), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .addr_i(sadr),
      .evt_cnt_o(evt), .last_cmd_o(lcmd));

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Cuts a hang short; the full run needs well under a fifth of this
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         give_verdict;
      end
   end

   // ==========================================================
   // Checking and expectations
   task chk(input bit ok, input string msg);
      num_checks++;
      if (!ok) begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Second ROM base by size code
   function automatic logic [23:0] rom_base(input logic [2:0] c);
      case (c)
         3'h6:    return 24'h20_0000;
         3'h5:    return 24'h10_0000;
         3'h4:    return 24'h08_0000;
         3'h3:    return 24'h04_0000;
         default: return 24'h02_0000;
      endcase
   endfunction

   // One event for a selected cycle, one for clock enable leaving its idle high
   function automatic logic [15:0] exp_evt(input logic [5:0] p);
      return 16'(!p[4]) + 16'(!p[5]);
   endfunction

   // ==========================================================
   // Bus and reset tasks (entered and left at a rising edge)
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      radr <= a;
      wdat <= d;
      wr   <= 1'b1;
      rd   <= 1'b0;
      @(posedge clk);
   endtask

   task rd_reg(input logic [7:0] a, output logic [15:0] q);
      radr <= a;
      rd   <= 1'b1;
      wr   <= 1'b0;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdat;
      @(posedge clk);
   endtask

   task cyc(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task do_reset(input logic z, input logic e, input logic [2:0] r);
      rst <= 1'b1;
      s64 <= z;
      cse <= e;
      rsz <= r;
      repeat (8) @(posedge clk);
      chk(cs_n === 1'b1 && cke === 1'b1 && ack === 1'b0 && rom_n === 1'b1, "reset pins");
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // ==========================================================
   // Memory map: outputs land one cycle after the address
   task dec_chk(input logic [23:0] a, input logic v);
      logic [23:0] b;
      logic        h;
      logic        r2;
      b  = rom_base(rsz);
      h  = s64 ? (a >= 24'h80_0000) : (a >= 24'h80_0000 && a <= 24'h9F_FFFF);
      r2 = v && !cse && rsz != 3'h7 && a >= b && a < {b[22:0], 1'b0};
      aadr <= a;
      aval <= v;
      @(posedge clk);
      #1;
      chk(hit === h, "bank range");
      if (h) chk(region === (s64 ? a[22:21] : {1'b0, a[20]}), "bank index");
      chk(ba === (s64 ? a[13:12] : {1'b0, a[11]}), "bank bits");
      chk(rom_n === !r2, "rom select");
      @(posedge clk);
   endtask

   task map_chk;
      logic [15:0] q;
      logic [23:0] b;
      b = rom_base(rsz);
      rd_reg(SDM_REG_CFG, q);
      chk(q[4:0] === {rsz, cse, s64}, "cfg read");
      foreach (PTS[i]) dec_chk(PTS[i], 1'b1);
      dec_chk(b - 24'h1, 1'b1);
      dec_chk(b, 1'b1);
      dec_chk({b[22:0], 1'b0} - 24'h1, 1'b1);
      dec_chk(b, 1'b0);
      repeat (3) dec_chk(24'($random(seed)), 1'b1);
   endtask

   // ==========================================================
   // One direct-mode command through the four phases
   task run_cmd(input logic [5:0] p);
      logic [15:0] q;
      logic [15:0] c0;
      int          k;
      c0 = evt;
      wr_reg(SDM_REG_DCMD, {10'h000, p});
      wr_reg(SDM_REG_CTRL, 16'h0001);
      // Pattern stands only in the cycle after the request lands
      cyc(1);
      #1;
      chk({cke, cs_n, ras_n, cas_n, we_n} === p[5:1], "pattern");
      chk(sadr[11:10] === {1'b0, p[0]}, "a10 pin");
      if (p[4:1] == 4'h0) chk(sadr[9:0] === 10'h032, "mode word");
      chk(ack === 1'b0, "early ack");
      k = 0;
      while (ack !== 1'b1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(k < 8, "ack wait");
      @(posedge clk);
      rd_reg(SDM_REG_CTRL, q);
      chk(q[1:0] === 2'h3, "ctrl flags");
      wr_reg(SDM_REG_CTRL, 16'h0001);
      cyc(4);
      #1;
      chk(ack === 1'b1 && cs_n === 1'b1 && cke === p[5], "hold");
      chk(evt === c0 + exp_evt(p), "once");
      if (!p[4]) chk(lcmd === p[3:0], "command seen");
      @(posedge clk);
      wr_reg(SDM_REG_CTRL, 16'h0000);
      cyc(2);
      #1;
      chk(ack === 1'b0, "ack release");
      @(posedge clk);
      cyc(3);
      c0 = evt;
      cyc(6);
      chk(evt === c0, "idle");
   endtask

   // Normal path drives the pins one cycle late outside direct mode
   task norm_chk;
      logic [16:0] v;
      v = 17'($random(seed));
      {nm_cke, nm_cs_n, nm_ras_n, nm_cas_n, nm_we_n, nm_adr} <= v;
      @(posedge clk);
      #1;
      chk({cke, cs_n, ras_n, cas_n, we_n, sadr} === v, "normal path");
      @(posedge clk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [15:0] q;
      rst      = 1'b1;
      wr       = 1'b0;
      rd       = 1'b0;
      radr     = 8'h00;
      wdat     = 16'h0000;
      s64      = 1'b0;
      cse      = 1'b1;
      rsz      = 3'h7;
      aadr     = 24'h00_0000;
      aval     = 1'b0;
      nm_cke   = 1'b1;
      nm_cs_n  = 1'b1;
      nm_ras_n = 1'b1;
      nm_cas_n = 1'b1;
      nm_we_n  = 1'b1;
      nm_adr   = 12'h000;
      for (int r = 0; r < 8; r++) begin
         do_reset(r[0], 1'b0, r[2:0]);
         map_chk;
      end
      do_reset(1'b1, 1'b1, 3'h6);
      map_chk;
      $display("test memory map done");
      rd_reg(SDM_REG_DCMD, q);
      chk(q === 16'h0000, "dcmd reset value");
      rd_reg(8'h07, q);
      chk(q === 16'h0000, "unmapped read");
      wr_reg(8'h07, 16'hFFFF);
      wr_reg(SDM_REG_CTRL, 16'h0002);
      rd_reg(SDM_REG_CTRL, q);
      chk(q[2:0] === 3'h4, "ack not writable");
      $display("test registers done");
      foreach (CMDS[i]) run_cmd(CMDS[i]);
      repeat (3) run_cmd(6'($random(seed)));
      $display("test direct mode done");
      repeat (20) norm_chk;
      $display("test normal path done");
      give_verdict;
   end
endmodule
